// file: branch_pkg.sv
package branch_pkg;
    // status register layout, bit positions
    localparam int status_width = 8;
    localparam logic [2:0] carry_bit = 3'h0;
    localparam logic [2:0] zero_bit = 3'h1;
    // program counter and offset widths
    localparam int pc_width_default = 16;
    localparam int offset_width_default = 7;
    localparam logic [15:0] pc_reset = 16'h0000;
    // cycles taken by a branch
    localparam int cycles_not_taken = 1;
    localparam int cycles_taken = 2;
    // branch kinds issued by the decoder
    typedef enum logic [2:0] {
        op_none = 3'h0,
        branch_on_status_bit_set = 3'h1,
        branch_on_status_bit_clear = 3'h2,
        branch_if_equal = 3'h3,
        branch_if_not_equal = 3'h4,
        branch_if_carry_set = 3'h5,
        branch_if_carry_clear = 3'h6
    } branch_op_type;
    // sequencer states, gray along fetch -> second cycle
    typedef enum logic {
        st_ready = 1'b0,
        st_second = 1'b1
    } seq_state_type;
endpackage : branch_pkg

// file: cond_if.sv
`timescale 1ns/1ps
interface cond_if;
    branch_pkg::branch_op_type op;
    logic [2:0] bit_select;
    logic [7:0] status_register;
    logic take;
    modport eval (input op, input bit_select, input status_register, output take);
    modport user (output op, output bit_select, output status_register, input take);
endinterface : cond_if

// file: branch_condition.sv
`timescale 1ns/1ps
module branch_condition (
    cond_if.eval c
);
    logic sel_bit;

    // pick the tested flag, then compare against the wanted polarity
    always_comb begin
        sel_bit = c.status_register[c.bit_select];
        unique case (c.op)
            branch_pkg::branch_on_status_bit_set: c.take = sel_bit; // see [RL1]
            branch_pkg::branch_on_status_bit_clear: c.take = ~sel_bit; // see [RL2]
            branch_pkg::branch_if_equal: c.take = c.status_register[branch_pkg::zero_bit]; // see [RL3]
            branch_pkg::branch_if_not_equal: c.take = ~c.status_register[branch_pkg::zero_bit]; // see [RL4]
            branch_pkg::branch_if_carry_set: c.take = c.status_register[branch_pkg::carry_bit]; // see [RL5]
            branch_pkg::branch_if_carry_clear: c.take = ~c.status_register[branch_pkg::carry_bit]; // see [RL6]
            default: c.take = 1'b0;
        endcase
    end
endmodule : branch_condition

// file: conditional_branch_unit.sv
// Function
// [RL1] status bit set: pc gets pc+k+1
// [RL2] status bit clear: pc gets pc+k+1
// [RL3] zero flag set: jump by k+1
// [RL4] zero flag clear: jump by k+1
// [RL5] carry flag set: jump by k+1
// [RL6] carry flag clear: jump by k+1
// [RL7] branches never alter status flags
// [RL8] one cycle untaken, two cycles taken
`timescale 1ns/1ps
module conditional_branch_unit #(
    parameter int pc_width = branch_pkg::pc_width_default,
    parameter int offset_width = branch_pkg::offset_width_default
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic issue,
    input wire branch_pkg::branch_op_type op,
    input wire logic [2:0] bit_select,
    input wire logic [offset_width-1:0] offset,
    input wire logic [branch_pkg::status_width-1:0] status_in,
    output logic ready,
    output logic done,
    output logic taken,
    output logic [pc_width-1:0] pc,
    output logic [branch_pkg::status_width-1:0] status_out
);
    // refuse widths the sign extension and pc port cannot serve
    if (pc_width < 2 || pc_width > 16 || offset_width < 2 || offset_width >= pc_width) begin : g_bad_width
        $error("conditional_branch_unit: unsupported widths");
    end

    cond_if c ();
    branch_pkg::seq_state_type state;
    branch_pkg::seq_state_type next_state;
    logic [pc_width-1:0] next_pc;
    logic [pc_width-1:0] target;
    logic [pc_width-1:0] next_target;
    logic next_done;
    logic next_taken;
    logic accept;

    assign c.op = op;
    assign c.bit_select = bit_select;
    assign c.status_register = status_in;

    branch_condition u_cond (
        .c(c.eval)
    );

    // a taken branch blocks new issue during its second cycle
    assign ready = (state == branch_pkg::st_ready);
    assign accept = issue && ready && (op != branch_pkg::op_none);
    // flags pass straight through; no path here writes them
    assign status_out = status_in; // see [RL7]

    // sequencer and program counter next values
    always_comb begin
        next_state = state;
        next_pc = pc;
        next_target = target;
        next_done = 1'b0;
        next_taken = 1'b0;
        unique case (state)
            branch_pkg::st_ready: begin
                if (accept) begin
                    // sign-extended offset plus one, wraps in the pc width
                    next_target = pc + pc_width'(signed'(offset)) + pc_width'(1);
                    if (c.take) begin
                        next_state = branch_pkg::st_second; // see [RL8]
                    end else begin
                        next_pc = pc + pc_width'(1); // see [RL8]
                        next_done = 1'b1;
                    end
                end
            end
            branch_pkg::st_second: begin
                // load happens on the second cycle, as the fetch is flushed
                next_pc = target; // see [RL1] see [RL3] see [RL5]
                next_done = 1'b1;
                next_taken = 1'b1;
                next_state = branch_pkg::st_ready;
            end
        endcase
    end

    // register state, pc, target, done and taken; synchronous reset
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state <= branch_pkg::st_ready;
            pc <= pc_width'(branch_pkg::pc_reset);
            target <= '0;
            done <= 1'b0;
            taken <= 1'b0;
        end else begin
            state <= next_state;
            pc <= next_pc;
            target <= next_target;
            done <= next_done;
            taken <= next_taken;
        end
    end
endmodule : conditional_branch_unit

// file: conditional_branch_unit_chk.sv
`timescale 1ns/1ps
module conditional_branch_unit_chk (
    input logic ref_clk, rstn, issue, ready, done, taken,
    input branch_pkg::branch_op_type op,
    input logic [2:0] bit_select,
    input logic [6:0] offset,
    input logic [7:0] status_in, status_out,
    input logic [15:0] pc
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // accepted issue, selected bit, and the target worked out at issue time
    wire a = issue && ready && op != 3'h0;
    wire s = status_in[bit_select];
    wire [15:0] t = pc + {{9{offset[6]}}, offset} + 1'b1;
    sequence s_hit; !ready ##1 done && taken && pc == $past(t, 2); endsequence
    property p_bs; a && op == 3'h1 && s |=> s_hit; endproperty
    a_bs: assert property (p_bs) else $error("bs");
    property p_bc; a && op == 3'h2 && !s |=> s_hit; endproperty
    a_bc: assert property (p_bc) else $error("bc");
    property p_eq; a && op == 3'h3 && status_in[1] |=> s_hit; endproperty
    a_eq: assert property (p_eq) else $error("eq");
    property p_ne; a && op == 3'h4 && !status_in[1] |=> s_hit; endproperty
    a_ne: assert property (p_ne) else $error("ne");
    property p_cs; a && op == 3'h5 && status_in[0] |=> s_hit; endproperty
    a_cs: assert property (p_cs) else $error("cs");
    property p_cc; a && op == 3'h6 && !status_in[0] |=> s_hit; endproperty
    a_cc: assert property (p_cc) else $error("cc");
    property p_keep; status_out == status_in; endproperty
    a_keep: assert property (p_keep) else $error("flags");
    property p_fall; a ##1 ready |-> done && !taken && pc == $past(pc) + 1'b1; endproperty
    a_fall: assert property (p_fall) else $error("fall");
    // main cases
    cover property (taken);
    cover property (done && !taken);
    cover property (issue && !ready);
endmodule : conditional_branch_unit_chk

// file: conditional_branch_unit_tb.sv
`timescale 1ns/1ps
module conditional_branch_unit_tb;
    logic ref_clk = 0, rstn = 0, issue = 0, ready, done, taken;
    branch_pkg::branch_op_type op = branch_pkg::op_none;
    logic [2:0] bit_select = 3'h0;
    logic [6:0] offset = 7'h40;
    logic [7:0] status_in = 8'h00, status_out;
    logic [15:0] pc, e = 16'h0000;
    int miscompares = 0, cmp_count = 0;
    conditional_branch_unit DUT (.*);
    initial forever #5 ref_clk = ~ref_clk;
    task chk(input string n, input logic [15:0] v, x);
        cmp_count++;
        miscompares += (v !== x);
        if (v !== x) $display("wrong value %s expected %h seen %h", n, x, v);
    endtask : chk
    // issue stays up through the stall, so it must be refused
    task br(input logic [2:0] o, input logic tk);
        @(posedge ref_clk);
        issue <= 1'b1;
        op <= branch_pkg::branch_op_type'(o);
        bit_select <= o + 3'h3;
        status_in <= {8{o[0] ^ tk}} ^ (8'h01 << (o < 3'h3 ? o + 3'h3 : o < 3'h5));
        @(posedge ref_clk);
        issue <= tk;
        e = e + (tk ? 16'hFFC1 : 16'h0001);
        #1 chk("done", done, !tk);
        chk("ready", ready, !tk);
        if (tk) begin
            @(posedge ref_clk) issue <= 1'b0;
            #1 chk("done", done, 1'b1);
        end
        chk("taken", taken, tk);
        chk("pc", pc, e);
        chk("flags", status_out, status_in);
    endtask : br
    task t_ops;
        for (int j = 1; j >= 0; j--) for (int i = 1; i < 7; i++) br(3'(i), j[0]);
    endtask : t_ops
    task tally_and_finish;
        $display("%0d compares, %0d wrong", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // reset held for 8 cycles, then every kind taken and falling through
    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        t_ops;
        tally_and_finish;
    end
endmodule : conditional_branch_unit_tb
bind conditional_branch_unit conditional_branch_unit_chk u_chk (.*);
